// ==== dv/stm_bus_master.sv ====
`timescale 1ns/10ps
// Register-port master standing in for the bus controller
module stm_bus_master
    import stm_pkg::*;
(
    // Clock in
    input wire logic core_clk,
    // Reset and register port out
    output logic rst_n,
    output logic regWr,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    // Read data in
    input wire logic [7:0] regRdata
);
    // Idle levels until the bench starts; reset held from time zero
    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end

    // master issues a reset to leave the fuse error
    task automatic reset_pulse(input int cycles);
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        repeat (cycles) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
    endtask : reset_pulse

    // One-cycle strobe, taken at the next rising edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        #1;
        regWr = 1'b1;
        regAddr = addr;
        regWdata = data;
        @(posedge core_clk);
        #1;
        regWr = 1'b0;
    endtask : write_reg

    // Address set off the edge, data taken at the following edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        #1;
        regAddr = addr;
        @(posedge core_clk);
        data = regRdata;
    endtask : read_reg

    // master keeps the fuse parity odd
    function automatic logic [7:0] with_fuse_par(input logic [6:0] fields, input logic [2:0] testHigh);
        with_fuse_par = {~^{fields, testHigh}, fields};
    endfunction : with_fuse_par
endmodule : stm_bus_master

// Bench top: register sequences with expected values
module test_stm_mode_regs
    import stm_pkg::*;
;
    logic core_clk = 1'b0; // Bench clock
    logic rst_n; // From the master
    logic regWr;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic [1:0] testSelect; // Test fields held by the bench
    logic [1:0] testPhaseSelect;
    logic shortRangeSel;
    logic [71:0] cfgBits;
    logic [2:0] testRegHigh;
    logic [1:0] busAddrSelect; // Mode fields
    logic readProtocolSel;
    logic collisionAvoidBit;
    logic intEnable;
    logic [1:0] powerMode;
    logic modeParityFlag; // Status
    logic configParityFlag;
    logic fuseError;
    logic wakeEnable;
    logic [2:0] srcX; // Channel sources
    logic [2:0] srcY;
    logic [2:0] srcZ;
    logic [2:0] srcT;
    logic [1:0] spinAxis;
    logic [1:0] integLong;
    logic [11:0] patX; // Registered patterns
    logic [11:0] patY;
    logic [11:0] patZ;
    logic [11:0] patT;
    int errCount; // Mismatches
    int compares; // Comparisons made

    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    stm_mode_regs uut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .regWr(regWr),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regRdata(regRdata),
        .testSelect(testSelect),
        .testPhaseSelect(testPhaseSelect),
        .shortRangeSel(shortRangeSel),
        .cfgBits(cfgBits),
        .testRegHigh(testRegHigh),
        .busAddrSelect(busAddrSelect),
        .readProtocolSel(readProtocolSel),
        .collisionAvoidBit(collisionAvoidBit),
        .intEnable(intEnable),
        .powerMode(powerMode),
        .modeParityFlag(modeParityFlag),
        .configParityFlag(configParityFlag),
        .fuseError(fuseError),
        .wakeEnable(wakeEnable),
        .srcX(srcX),
        .srcY(srcY),
        .srcZ(srcZ),
        .srcT(srcT),
        .spinAxis(spinAxis),
        .integLong(integLong),
        .patX(patX),
        .patY(patY),
        .patZ(patZ),
        .patT(patT)
    );

    stm_bus_master uBus (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .regWr(regWr),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regRdata(regRdata)
    );

    // Single compare point; four-state compare so unknowns fail
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Pattern table: X, Y, Z then temperature
    function automatic logic [47:0] exp_pat(input logic [1:0] ph, input logic sr);
        logic [35:0] xyz;
        logic [11:0] tmp;
        case ({sr, ph})
            3'h0: xyz = {12'h7F9, 12'h806, 12'h7FF};
            3'h1: xyz = {12'h806, 12'h7F9, 12'h800};
            3'h2: xyz = {12'h7FF, 12'h800, 12'h7F9};
            3'h3: xyz = {12'h800, 12'h7FF, 12'h806};
            3'h4, 3'h6: xyz = {12'h7FF, 12'h800, 12'h7FF};
            default: xyz = {12'h800, 12'h7FF, 12'h800};
        endcase
        case (ph)
            2'h0: tmp = 12'h200;
            2'h1: tmp = 12'h1FF;
            2'h2: tmp = 12'h201;
            default: tmp = 12'h1FE;
        endcase
        exp_pat = {xyz, tmp};
    endfunction : exp_pat

    // Set test fields, then check sources and registered patterns
    task automatic apply_test(input logic [1:0] ts, input logic [1:0] ph, input logic sr);
        logic [47:0] pat;
        logic [2:0] fld;
        logic [2:0] tmpSrc;
        pat = exp_pat(ph, sr);
        fld = (ts == 2'h0) ? (sr ? SRC_SHORT : SRC_FULL) : (ts == 2'h1) ? SRC_HALL :
              (ts == 2'h2) ? SRC_SPIN : SRC_PATTERN;
        tmpSrc = (ts == 2'h0) ? SRC_FULL : (ts == 2'h1) ? SRC_VDD : fld;
        @(posedge core_clk);
        #1;
        testSelect = ts;
        testPhaseSelect = ph;
        shortRangeSel = sr;
        @(posedge core_clk);
        #2;
        check("srcX", 16'(srcX), 16'(fld));
        check("srcY", 16'(srcY), 16'(fld));
        check("srcZ", 16'(srcZ), 16'(fld));
        check("srcT", 16'(srcT), 16'(tmpSrc));
        check("spinAxis", 16'(spinAxis), 16'(ph));
        check("integLong", 16'(integLong), 16'({1'b0, (ts == 2'h0) && sr}));
        check("patX", 16'(patX), 16'(pat[47:36]));
        check("patY", 16'(patY), 16'(pat[35:24]));
        check("patZ", 16'(patZ), 16'(pat[23:12]));
        check("patT", 16'(patT), 16'(pat[11:0]));
    endtask : apply_test

    // Counts, verdict and end of run
    task automatic wrap_up;
        $display("Mismatches %0d, comparisons %0d", errCount, compares);
        if (errCount == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // Register sequences
    initial begin
        logic [7:0] rd;
        logic [7:0] good;
        errCount = 0;
        compares = 0;
        testSelect = 2'h0;
        testPhaseSelect = 2'h0;
        shortRangeSel = 1'b0;
        cfgBits = 72'h0;
        testRegHigh = 3'h5;
        uBus.reset_pulse(8);
        uBus.read_reg(MODE_ADDR, rd);
        check("mode reset", 16'(rd), 16'h0080);
        uBus.read_reg(DIAG_ADDR, rd);
        check("diag reset", 16'(rd), 16'h0000);
        // Well-formed mode write
        good = uBus.with_fuse_par(7'h35, testRegHigh);
        check("fuse parity byte", 16'(good), 16'h00B5);
        uBus.write_reg(MODE_ADDR, good);
        check("busAddrSelect", 16'(busAddrSelect), 16'(good[6:5]));
        check("readProtocolSel", 16'(readProtocolSel), 16'(good[4]));
        check("collisionAvoidBit", 16'(collisionAvoidBit), 16'(good[3]));
        check("intEnable", 16'(intEnable), 16'(good[2]));
        check("powerMode", 16'(powerMode), 16'(good[1:0]));
        check("modeParityFlag", 16'(modeParityFlag), 16'h0001);
        check("fuseError good", 16'(fuseError), 16'h0000);
        // Other addresses leave the mode register alone
        uBus.write_reg(DIAG_ADDR, 8'hFF);
        uBus.read_reg(MODE_ADDR, rd);
        check("mode readback", 16'(rd), 16'(good));
        // Config parity, odd then even
        cfgBits = 72'h1;
        uBus.write_reg(CFG_FIRST_ADDR, 8'h01);
        check("configParityFlag", 16'(configParityFlag), 16'h0001);
        check("wakeEnable odd", 16'(wakeEnable), 16'h0001);
        uBus.read_reg(DIAG_ADDR, rd);
        check("diag flags", 16'(rd), 16'h0030);
        cfgBits = 72'h3;
        uBus.write_reg(CFG_LAST_ADDR, 8'h00);
        check("wakeEnable even", 16'(wakeEnable), 16'h0000);
        // Bad fuse parity latches until reset
        uBus.write_reg(MODE_ADDR, 8'h35);
        check("fuseError bad", 16'(fuseError), 16'h0001);
        check("modeParityFlag bad", 16'(modeParityFlag), 16'h0000);
        uBus.write_reg(MODE_ADDR, good);
        check("fuseError sticky", 16'(fuseError), 16'h0001);
        uBus.reset_pulse(2);
        check("fuseError reset", 16'(fuseError), 16'h0000);
        check("wakeEnable reset", 16'(wakeEnable), 16'h0000);
        uBus.read_reg(MODE_ADDR, rd);
        check("mode after reset", 16'(rd), 16'h0080);
        // Every test mode, phase and range
        for (int i = 0; i < 32; i++) begin
            apply_test(i[4:3], i[2:1], i[0]);
        end
        wrap_up();
    end
endmodule : test_stm_mode_regs

// ==== hdl/stm_mode_regs.sv ====
`timescale 1ns/10ps
// Function
// R1: Test select 11 reports fixed patterns
// R2: Test select 10 runs per-axis spin test
// R3: 00 normal results, 01 raw voltages
// R4: Mode register accesses carry parity flag
// R5: Mode parity flag readable at 06h
// R6: Fuse parity odd over 11h, 13h[7:5]
// R7: Fuse parity failure latches until reset
// R8: Mode reset value depends on variant
// R9: Mode register field layout fixed
// R10: Short range doubles field integration only
// R11: Config parity odd over 07h-10h, gates wake
module stm_mode_regs
    import stm_pkg::*;
#(
    parameter int VARIANT = 0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port from the bus engine
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Config and test fields held elsewhere
    input wire logic [1:0] testSelect,
    input wire logic [1:0] testPhaseSelect,
    input wire logic shortRangeSel,
    input wire logic [71:0] cfgBits,
    input wire logic [2:0] testRegHigh,
    // Mode fields out
    output logic [1:0] busAddrSelect,
    output logic readProtocolSel,
    output logic collisionAvoidBit,
    output logic intEnable,
    output logic [1:0] powerMode,
    // Status out
    output logic modeParityFlag,
    output logic configParityFlag,
    output logic fuseError,
    output logic wakeEnable,
    // Channel source selection and pattern data out
    output logic [2:0] srcX,
    output logic [2:0] srcY,
    output logic [2:0] srcZ,
    output logic [2:0] srcT,
    output logic [1:0] spinAxis,
    output logic [1:0] integLong,
    output logic [11:0] patX,
    output logic [11:0] patY,
    output logic [11:0] patZ,
    output logic [11:0] patT
);

    // Only four product variants exist
    if (VARIANT < 0 || VARIANT > 3) begin : g_bad_variant
        $error("VARIANT must be 0 to 3");
    end

    // Reset value chosen by product variant
    // R8: variant reset value
    localparam logic [7:0] MODE_RST = (VARIANT == 1) ? MODE_RST_A1 :
                                      (VARIANT == 2) ? MODE_RST_A2 :
                                      (VARIANT == 3) ? MODE_RST_A3 : MODE_RST_A0;

    logic [7:0] modeQ, modeD; // Mode register
    logic fuseErrQ; // Sticky fuse error
    logic modeParQ; // Mode parity flag
    logic cfgParQ; // Config parity flag
    logic [11:0] patXd, patYd, patZd, patTd; // Pattern lookup
    stm_test_t testMode;

    // Decodes
    wire modeWr = regWr && (regAddr == MODE_ADDR);
    wire cfgWr = regWr && (regAddr >= CFG_FIRST_ADDR) && (regAddr <= CFG_LAST_ADDR);
    // R6: odd parity over fuse fields
    wire fuseOdd = ^{modeD, testRegHigh};
    // R11: odd parity over config, test bits excluded by caller
    wire cfgOdd = ^cfgBits;
    assign testMode = stm_test_t'(testSelect);

    // Next mode value
    assign modeD = modeWr ? regWdata : modeQ;

    // Mode register, loaded on any mode write; parity flag only records it
    // R4: parity flag on mode access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeQ <= MODE_RST;
            modeParQ <= 1'b0;
        end else begin
            modeQ <= modeD;
            if (modeWr) begin
                modeParQ <= fuseOdd;
            end
        end
    end

    // Sticky fuse error: only reset leaves it
    // R7: error latches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fuseErrQ <= 1'b0;
        end else if (modeWr && !fuseOdd) begin
            fuseErrQ <= 1'b1;
        end
    end

    // Config parity checked on each config write; false after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgParQ <= 1'b0;
        end else if (cfgWr) begin
            cfgParQ <= cfgOdd;
        end
    end

    // R9: field layout
    assign busAddrSelect = modeQ[ADDR_SEL_HI:ADDR_SEL_LO];
    assign readProtocolSel = modeQ[READ_PROT_POS];
    assign collisionAvoidBit = modeQ[COLL_AVOID_POS];
    assign intEnable = modeQ[INT_EN_POS];
    assign powerMode = modeQ[PWR_MODE_HI:0];
    assign fuseError = fuseErrQ;
    assign configParityFlag = cfgParQ;
    // R11: wrong parity disables wake
    assign wakeEnable = cfgParQ;
    // R5: flag shown in diagnostics
    assign modeParityFlag = modeParQ;

    // Read mux, unmapped reads zero
    always_comb begin
        regRdata = 8'h00;
        if (regAddr == MODE_ADDR) begin
            regRdata = modeQ;
        end else if (regAddr == DIAG_ADDR) begin
            regRdata[DIAG_MODE_PAR_POS] = modeParQ;
            regRdata[DIAG_CFG_PAR_POS] = cfgParQ;
        end
    end

    // Channel sources per test mode
    always_comb begin
        srcX = SRC_FULL;
        srcY = SRC_FULL;
        srcZ = SRC_FULL;
        srcT = SRC_FULL;
        unique case (testMode)
            // R3: normal and raw
            TMODE_NORMAL: begin
                srcX = shortRangeSel ? SRC_SHORT : SRC_FULL;
                srcY = shortRangeSel ? SRC_SHORT : SRC_FULL;
                srcZ = shortRangeSel ? SRC_SHORT : SRC_FULL;
            end
            TMODE_RAW: begin
                srcX = SRC_HALL;
                srcY = SRC_HALL;
                srcZ = SRC_HALL;
                srcT = SRC_VDD;
            end
            // R2: spin test, channel n has spin n off
            TMODE_SPIN: begin
                srcX = SRC_SPIN;
                srcY = SRC_SPIN;
                srcZ = SRC_SPIN;
                srcT = SRC_SPIN;
            end
            // R1: fixed patterns
            TMODE_PATTERN: begin
                srcX = SRC_PATTERN;
                srcY = SRC_PATTERN;
                srcZ = SRC_PATTERN;
                srcT = SRC_PATTERN;
            end
        endcase
    end
    assign spinAxis = testPhaseSelect;
    // R10: long integration for field only, in normal mode
    assign integLong = {1'b0, (testMode == TMODE_NORMAL) && shortRangeSel};

    // R1: pattern lookup
    stm_pattern_rom uRom (
        .phase(testPhaseSelect),
        .shortRange(shortRangeSel),
        .patX(patXd),
        .patY(patYd),
        .patZ(patZd),
        .patT(patTd)
    );

    // Registered pattern data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            patX <= 12'h000;
            patY <= 12'h000;
            patZ <= 12'h000;
            patT <= 12'h000;
        end else begin
            patX <= patXd;
            patY <= patYd;
            patZ <= patZd;
            patT <= patTd;
        end
    end

    // Assertions
    a_fuse_err_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        fuseErrQ |=> fuseErrQ) else $error("fuse error dropped"); // R7
    a_fuse_err_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (modeWr && !fuseOdd) |=> fuseErrQ) else $error("fuse error not set"); // R6
    a_mode_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        modeWr |=> modeQ == $past(regWdata)) else $error("mode not written"); // R9
    a_par_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        modeWr |=> modeParityFlag == $past(fuseOdd)) else $error("parity flag wrong"); // R4
    a_diag_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        regAddr == DIAG_ADDR |-> regRdata[DIAG_MODE_PAR_POS] == modeParQ) else $error("diag flag"); // R5
    a_pat_temp: assert property (@(posedge core_clk) disable iff (!rst_n)
        testPhaseSelect == 2'h0 |=> patT == 12'h200) else $error("temp pattern"); // R1
    a_pat_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        testMode == TMODE_PATTERN |-> srcT == SRC_PATTERN) else $error("pattern source"); // R1
    a_spin_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        testMode == TMODE_SPIN |-> srcX == SRC_SPIN && spinAxis == testPhaseSelect) else $error("spin"); // R2
    a_short_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        testMode == TMODE_NORMAL |-> srcT == SRC_FULL && integLong[0] == shortRangeSel) else $error("range"); // R10
    a_wake_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cfgWr && !cfgOdd) |=> !wakeEnable) else $error("wake not gated"); // R11

endmodule : stm_mode_regs

// ==== hdl/stm_pattern_rom.sv ====
`timescale 1ns/10ps
// Fixed test patterns, indexed by phase and short-range bit
module stm_pattern_rom
    import stm_pkg::*;
(
    // Selection
    input wire logic [1:0] phase,
    input wire logic shortRange,
    // Patterns, three field channels and temperature
    output logic [11:0] patX,
    output logic [11:0] patY,
    output logic [11:0] patZ,
    output logic [11:0] patT
);

    // Combinational lookup; the parent registers the results
    always_comb begin
        patX = 12'h000;
        patY = 12'h000;
        patZ = 12'h000;
        unique case ({shortRange, phase})
            3'h0: begin
                patX = 12'h7F9;
                patY = 12'h806;
                patZ = 12'h7FF;
            end
            3'h1: begin
                patX = 12'h806;
                patY = 12'h7F9;
                patZ = 12'h800;
            end
            3'h2: begin
                patX = 12'h7FF;
                patY = 12'h800;
                patZ = 12'h7F9;
            end
            3'h3: begin
                patX = 12'h800;
                patY = 12'h7FF;
                patZ = 12'h806;
            end
            3'h4, 3'h6: begin
                patX = 12'h7FF;
                patY = 12'h800;
                patZ = 12'h7FF;
            end
            3'h5, 3'h7: begin
                patX = 12'h800;
                patY = 12'h7FF;
                patZ = 12'h800;
            end
        endcase
    end

    // Temperature pattern ignores the short-range bit
    always_comb begin
        unique case (phase)
            2'h0: patT = 12'h200;
            2'h1: patT = 12'h1FF;
            2'h2: patT = 12'h201;
            2'h3: patT = 12'h1FE;
        endcase
    end

endmodule : stm_pattern_rom

// ==== hdl/stm_pkg.sv ====
package stm_pkg;

    // Mode register layout, from the top bit down
    localparam int FUSE_PAR_POS = 7;
    localparam int ADDR_SEL_HI = 6;
    localparam int ADDR_SEL_LO = 5;
    localparam int READ_PROT_POS = 4;
    localparam int COLL_AVOID_POS = 3;
    localparam int INT_EN_POS = 2;
    localparam int PWR_MODE_HI = 1;

    // Register addresses on the internal register port
    localparam logic [7:0] DIAG_ADDR = 8'h06;
    localparam logic [7:0] CFG_FIRST_ADDR = 8'h07;
    localparam logic [7:0] CFG_LAST_ADDR = 8'h10;
    localparam logic [7:0] FUSE_ADDR = 8'h11;
    localparam logic [7:0] MODE_ADDR = 8'h11;
    localparam logic [7:0] TEST_ADDR = 8'h13;

    // Mode register reset values per product variant
    localparam logic [7:0] MODE_RST_A0 = 8'h80;
    localparam logic [7:0] MODE_RST_A1 = 8'h20;
    localparam logic [7:0] MODE_RST_A2 = 8'h40;
    localparam logic [7:0] MODE_RST_A3 = 8'hE0;

    // Diagnostic register bit positions
    localparam int DIAG_MODE_PAR_POS = 4;
    localparam int DIAG_CFG_PAR_POS = 5;

    // Test selector encodings
    typedef enum logic [1:0] {
        TMODE_NORMAL = 2'h0,
        TMODE_RAW = 2'h1,
        TMODE_SPIN = 2'h2,
        TMODE_PATTERN = 2'h3
    } stm_test_t;

    // Result source codes for the converter front end
    localparam logic [2:0] SRC_FULL = 3'h0;
    localparam logic [2:0] SRC_SHORT = 3'h1;
    localparam logic [2:0] SRC_HALL = 3'h2;
    localparam logic [2:0] SRC_VDD = 3'h3;
    localparam logic [2:0] SRC_SPIN = 3'h4;
    localparam logic [2:0] SRC_PATTERN = 3'h5;

endpackage : stm_pkg
